// ==== rtl/rfesr_pkg.sv ====
// constants and carrier types for the receive frame error and status reporter
package rfesr_pkg;

   // frame check sequence
   localparam logic [31:0] CRC_INIT        = 32'hffffffff;
   localparam logic [31:0] CRC_POLY        = 32'hedb88320;
   localparam logic [31:0] CRC_RESIDUE     = 32'hdebb20e3;

   // frame size limits and overhead
   localparam logic [15:0] LEN_TYPE_LIMIT  = 16'h0600;
   localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
   localparam logic [15:0] MAX_FRAME_RESET = 16'h05ee;
   localparam logic [15:0] BASE_OVERHEAD   = 16'h0012;
   localparam logic [15:0] TAG_BYTES       = 16'h0004;

   // ethertypes and mac control opcodes
   localparam logic [15:0] ETH_VLAN        = 16'h8100;
   localparam logic [15:0] ETH_SVLAN       = 16'h88a8;
   localparam logic [15:0] ETH_CTRL        = 16'h8808;
   localparam logic [15:0] OP_PAUSE        = 16'h0001;
   localparam logic [15:0] OP_PFC          = 16'h0101;

   // header byte positions
   localparam int HDR_BYTES       = 34;
   localparam int POS_TYPE0       = 12;
   localparam int POS_OPCODE      = 14;
   localparam int POS_TYPE1       = 16;
   localparam int POS_TYPE2       = 20;
   localparam int POS_QUANTA      = 16;
   localparam int POS_CLASS_EN    = 17;
   localparam int POS_PFC_QUANTA  = 18;

   // error vector and interrupt status bit positions
   localparam int ERR_LEN         = 4;
   localparam int ERR_OVER        = 3;
   localparam int ERR_UNDER       = 2;
   localparam int ERR_CRC         = 1;
   localparam int ERR_MALFORMED   = 0;
   localparam int IRQ_PAUSE       = 5;

   // register map and bus answers
   localparam logic [7:0]  ADDR_MAX_SIZE   = 8'h00;
   localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h08;
   localparam logic [7:0]  ADDR_INFO_LO    = 8'h0c;
   localparam logic [7:0]  ADDR_INFO_HI    = 8'h10;
   localparam logic [7:0]  ADDR_PAUSE      = 8'h14;
   localparam logic [5:0]  IRQ_RESET       = 6'h00;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef logic [HDR_BYTES-1:0][7:0] rfesr_hdr_t;

   typedef struct packed {
      logic        pfc;
      logic        unicast;
      logic        multicast;
      logic        broadcast;
      logic        pause;
      logic        control;
      logic        vlan;
      logic        stackedVlan;
      logic [15:0] frameLen;
      logic [15:0] payloadLen;
   } rfesr_info_t;

   typedef struct packed {
      logic [63:0] data;
      logic        first;
      logic        last;
      logic [2:0]  empty;
      logic        badTerm;
   } rfesr_beat_t;

endpackage

// ==== rtl/rfesr_rx_report.sv ====
// receive frame error vector, frame status word and pause indication with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - six-bit error vector, valid only at end
// - bit 4: payload shorter than length field
// - bit 3: frame exceeds programmed maximum size
// - bit 2: frame under 64 bytes
// - bit 1: frame check sequence mismatch
// - bit 0: ended by non-terminate control
// - malformed packet also raises check error
// - status strobe marks valid 40-bit status word
// - bits 39..36: pfc, unicast, multicast, broadcast
// - bits 35..32: pause, control, vlan, stacked
// - bits 31..16: frame length incl. check sequence
// - bits 15..0: payload length in bytes
// - one held pause bit per flow queue
// - unused byte count in low lanes at end
// - start indication on first beat of frame
module rfesr_rx_report #(
   parameter int FLOW_QUEUE_COUNT = 8,
   parameter int QUANTUM_CYCLES   = 1
) (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst_b,
   // stream from the receive datapath
   input  wire logic                        inValid,
   input  wire rfesr_pkg::rfesr_beat_t      inBeat,
   // stream toward the client
   output logic                             rxValid,
   output logic [63:0]                      rxData,
   output logic                             rxFirstBeat,
   output logic                             rxLastBeat,
   output logic [2:0]                       rxUnusedByteCount,
   output logic [5:0]                       rxErrVec,
   output logic                             rxFrameInfoStrobe,
   output rfesr_pkg::rfesr_info_t           rxFrameInfoWord,
   output logic [FLOW_QUEUE_COUNT-1:0]      pauseVec,
   output logic                             irq,
   // axi4-lite slave
   input  wire logic [7:0]                  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [7:0]                  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready
);

   localparam int TICK_W = $clog2(QUANTUM_CYCLES + 1);

   typedef struct packed {
      logic                                 outValid;
      logic [63:0]                          outData;
      logic                                 outFirst;
      logic                                 outLast;
      logic [2:0]                           outEmpty;
      logic [5:0]                           errVec;
      logic                                 infoStrobe;
      rfesr_pkg::rfesr_info_t               info;
      logic [31:0]                          crc;
      logic [15:0]                          byteCnt;
      rfesr_pkg::rfesr_hdr_t                hdr;
      logic [FLOW_QUEUE_COUNT-1:0][15:0]    pauseCnt;
      logic [FLOW_QUEUE_COUNT-1:0]          pauseOut;
      logic [TICK_W-1:0]                    tickCnt;
      logic [15:0]                          maxSize;
      logic [5:0]                           irqStatus;
      logic [5:0]                           irqMask;
      logic                                 irq;
      logic                                 awHeld;
      logic                                 wHeld;
      logic [7:0]                           awAddr;
      logic [31:0]                          wData;
      logic [3:0]                           wStrb;
      logic                                 awready;
      logic                                 wready;
      logic                                 bvalid;
      logic [1:0]                           bresp;
      logic                                 arready;
      logic                                 rvalid;
      logic [1:0]                           rresp;
      logic [31:0]                          rdata;
   } rfesr_state_t;

   rfesr_state_t s_reg;
   rfesr_state_t s_next;

   logic [3:0]  lanes;
   logic [7:0]  byteVal;
   logic        tick;
   logic [15:0] typeOuter;
   logic [15:0] typeMid;
   logic [15:0] lenType;
   logic [15:0] opcode;
   logic [15:0] overhead;
   logic [15:0] payload;
   logic        isVlan;
   logic        isStacked;
   logic        crcBad;
   logic [5:0]  events;
   logic [5:0]  clearBits;
   logic [31:0] wordNext;

   // reflected crc32 over one byte
   function automatic logic [31:0] crcByte(input logic [31:0] crc, input logic [7:0] d);
      logic [31:0] c;
      c = crc ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ rfesr_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   // big-endian 16-bit field from the captured header
   function automatic logic [15:0] be16(input rfesr_pkg::rfesr_hdr_t h, input int pos);
      return {h[pos], h[pos+1]};
   endfunction

   // byte-lane merge of a write
   function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      s_next    = s_reg;
      lanes     = 4'h8;
      byteVal   = 8'h00;
      typeOuter = 16'h0000;
      typeMid   = 16'h0000;
      lenType   = 16'h0000;
      opcode    = 16'h0000;
      overhead  = rfesr_pkg::BASE_OVERHEAD;
      payload   = 16'h0000;
      isVlan    = 1'b0;
      isStacked = 1'b0;
      crcBad    = 1'b0;
      events    = 6'h00;
      clearBits = 6'h00;
      wordNext  = 32'h00000000;

      // pass the beat through one register stage
      s_next.outValid   = inValid;
      s_next.outData    = inBeat.data;
      s_next.outFirst   = inValid & inBeat.first;
      s_next.outLast    = inValid & inBeat.last;
      s_next.outEmpty   = (inValid & inBeat.last) ? inBeat.empty : 3'h0;
      s_next.errVec     = 6'h00;
      s_next.infoStrobe = 1'b0;

      // pause quantum divider and countdown
      tick             = (s_reg.tickCnt == TICK_W'(QUANTUM_CYCLES - 1));
      s_next.tickCnt   = tick ? '0 : s_reg.tickCnt + 1'b1;
      for (int q = 0; q < FLOW_QUEUE_COUNT; q++) begin
         if (tick && s_reg.pauseCnt[q] != 16'h0000) begin
            s_next.pauseCnt[q] = s_reg.pauseCnt[q] - 16'h0001;
         end
      end

      if (inValid) begin
         if (inBeat.first) begin
            s_next.crc     = rfesr_pkg::CRC_INIT;
            s_next.byteCnt = 16'h0000;
            s_next.hdr     = '0;
         end
         lanes = inBeat.last ? 4'h8 - {1'b0, inBeat.empty} : 4'h8;
         for (int b = 0; b < 8; b++) begin
            if (4'(b) < lanes) begin
               byteVal    = inBeat.data[63-8*b -: 8];
               s_next.crc = crcByte(s_next.crc, byteVal);
               if (s_next.byteCnt < 16'(rfesr_pkg::HDR_BYTES)) begin
                  s_next.hdr[s_next.byteCnt[5:0]] = byteVal;
               end
               if (s_next.byteCnt != 16'hffff) begin
                  s_next.byteCnt = s_next.byteCnt + 16'h0001;
               end
            end
         end

         if (inBeat.last) begin
            typeOuter = be16(s_next.hdr, rfesr_pkg::POS_TYPE0);
            typeMid   = be16(s_next.hdr, rfesr_pkg::POS_TYPE1);
            isVlan    = (typeOuter == rfesr_pkg::ETH_VLAN) || (typeOuter == rfesr_pkg::ETH_SVLAN);
            isStacked = isVlan && (typeMid == rfesr_pkg::ETH_VLAN);
            lenType   = isStacked ? be16(s_next.hdr, rfesr_pkg::POS_TYPE2) : (isVlan ? typeMid : typeOuter);
            opcode    = be16(s_next.hdr, rfesr_pkg::POS_OPCODE);
            overhead  = rfesr_pkg::BASE_OVERHEAD + (isVlan ? rfesr_pkg::TAG_BYTES : 16'h0000)
                        + (isStacked ? rfesr_pkg::TAG_BYTES : 16'h0000);
            payload   = (s_next.byteCnt > overhead) ? s_next.byteCnt - overhead : 16'h0000;
            crcBad    = (s_next.crc != rfesr_pkg::CRC_RESIDUE) || inBeat.badTerm;

            s_next.errVec[rfesr_pkg::ERR_MALFORMED] = inBeat.badTerm;
            s_next.errVec[rfesr_pkg::ERR_CRC]       = crcBad;
            s_next.errVec[rfesr_pkg::ERR_UNDER]     = s_next.byteCnt < rfesr_pkg::MIN_FRAME_BYTES;
            s_next.errVec[rfesr_pkg::ERR_OVER]      = s_next.byteCnt > s_reg.maxSize;
            s_next.errVec[rfesr_pkg::ERR_LEN]       = (lenType < rfesr_pkg::LEN_TYPE_LIMIT)
                                                      && (payload < lenType);

            s_next.infoStrobe       = 1'b1;
            s_next.info.broadcast   = (s_next.hdr[5:0] == 48'hffffffffffff);
            s_next.info.multicast   = s_next.hdr[0][0] && !s_next.info.broadcast;
            s_next.info.unicast     = !s_next.hdr[0][0];
            s_next.info.control     = !isVlan && (lenType == rfesr_pkg::ETH_CTRL);
            s_next.info.pause       = s_next.info.control && (opcode == rfesr_pkg::OP_PAUSE);
            s_next.info.pfc         = s_next.info.control && (opcode == rfesr_pkg::OP_PFC);
            s_next.info.vlan        = isVlan;
            s_next.info.stackedVlan = isStacked;
            s_next.info.frameLen    = s_next.byteCnt;
            s_next.info.payloadLen  = payload;

            // only a clean frame may pause the queues
            if (s_next.errVec == 6'h00) begin
               for (int q = 0; q < FLOW_QUEUE_COUNT; q++) begin
                  if (s_next.info.pause) begin
                     s_next.pauseCnt[q] = be16(s_next.hdr, rfesr_pkg::POS_QUANTA);
                  end else if (s_next.info.pfc && s_next.hdr[rfesr_pkg::POS_CLASS_EN][q]) begin
                     s_next.pauseCnt[q] = be16(s_next.hdr, rfesr_pkg::POS_PFC_QUANTA + 2*q);
                  end
               end
               events[rfesr_pkg::IRQ_PAUSE] = s_next.info.pause | s_next.info.pfc;
            end
            events[4:0] = s_next.errVec[4:0];
         end
      end

      for (int q = 0; q < FLOW_QUEUE_COUNT; q++) begin
         s_next.pauseOut[q] = (s_next.pauseCnt[q] != 16'h0000);
      end

      // write channel: take address and data in either order
      if (awvalid && s_reg.awready) begin
         s_next.awHeld = 1'b1;
         s_next.awAddr = awaddr;
      end
      if (wvalid && s_reg.wready) begin
         s_next.wHeld = 1'b1;
         s_next.wData = wdata;
         s_next.wStrb = wstrb;
      end
      if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.awHeld && s_reg.wHeld && !s_reg.bvalid) begin
         s_next.awHeld = 1'b0;
         s_next.wHeld  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = rfesr_pkg::RESP_OKAY;
         if (s_reg.awAddr == rfesr_pkg::ADDR_MAX_SIZE) begin
            wordNext       = applyStrb({16'h0000, s_reg.maxSize}, s_reg.wData, s_reg.wStrb);
            s_next.maxSize = wordNext[15:0];
         end else if (s_reg.awAddr == rfesr_pkg::ADDR_IRQ_STATUS) begin
            wordNext  = applyStrb(32'h00000000, s_reg.wData, s_reg.wStrb);
            clearBits = wordNext[5:0];
         end else if (s_reg.awAddr == rfesr_pkg::ADDR_IRQ_MASK) begin
            wordNext       = applyStrb({26'h0000000, s_reg.irqMask}, s_reg.wData, s_reg.wStrb);
            s_next.irqMask = wordNext[5:0];
         end else if (s_reg.awAddr == rfesr_pkg::ADDR_INFO_LO || s_reg.awAddr == rfesr_pkg::ADDR_INFO_HI
                      || s_reg.awAddr == rfesr_pkg::ADDR_PAUSE) begin
            s_next.bresp = rfesr_pkg::RESP_OKAY;
         end else begin
            s_next.bresp = rfesr_pkg::RESP_SLVERR;
         end
      end

      // sticky status: a new event wins over a clear in the same cycle
      s_next.irqStatus = (s_reg.irqStatus & ~clearBits) | events;
      s_next.irq       = |(s_next.irqStatus & s_next.irqMask);

      // read channel
      if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
      if (arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = rfesr_pkg::RESP_OKAY;
         s_next.rdata  = 32'h00000000;
         if (araddr == rfesr_pkg::ADDR_MAX_SIZE) begin
            s_next.rdata = {16'h0000, s_reg.maxSize};
         end else if (araddr == rfesr_pkg::ADDR_IRQ_STATUS) begin
            s_next.rdata = {26'h0000000, s_reg.irqStatus};
         end else if (araddr == rfesr_pkg::ADDR_IRQ_MASK) begin
            s_next.rdata = {26'h0000000, s_reg.irqMask};
         end else if (araddr == rfesr_pkg::ADDR_INFO_LO) begin
            s_next.rdata = s_reg.info[31:0];
         end else if (araddr == rfesr_pkg::ADDR_INFO_HI) begin
            s_next.rdata = {24'h000000, s_reg.info[39:32]};
         end else if (araddr == rfesr_pkg::ADDR_PAUSE) begin
            s_next.rdata = 32'(s_reg.pauseOut);
         end else begin
            s_next.rresp = rfesr_pkg::RESP_SLVERR;
         end
      end

      s_next.awready = !s_next.awHeld && !s_next.bvalid;
      s_next.wready  = !s_next.wHeld && !s_next.bvalid;
      s_next.arready = !s_next.rvalid;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg           <= '0;
         s_reg.maxSize   <= rfesr_pkg::MAX_FRAME_RESET;
         s_reg.crc       <= rfesr_pkg::CRC_INIT;
         s_reg.irqStatus <= rfesr_pkg::IRQ_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rxValid           = s_reg.outValid;
   assign rxData            = s_reg.outData;
   assign rxFirstBeat       = s_reg.outFirst;
   assign rxLastBeat        = s_reg.outLast;
   assign rxUnusedByteCount = s_reg.outEmpty;
   assign rxErrVec          = s_reg.errVec;
   assign rxFrameInfoStrobe = s_reg.infoStrobe;
   assign rxFrameInfoWord   = s_reg.info;
   assign pauseVec          = s_reg.pauseOut;
   assign irq               = s_reg.irq;
   assign awready           = s_reg.awready;
   assign wready            = s_reg.wready;
   assign bvalid            = s_reg.bvalid;
   assign bresp             = s_reg.bresp;
   assign arready           = s_reg.arready;
   assign rvalid            = s_reg.rvalid;
   assign rresp             = s_reg.rresp;
   assign rdata             = s_reg.rdata;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   AST_ERR_AT_END: assert property (rxErrVec != 6'h00 |-> rxLastBeat)
      else $error("error vector set away from end of packet");
   AST_TOP_UNUSED: assert property (!rxErrVec[5])
      else $error("unused error bit raised");
   AST_LEN_ERR: assert property (rxErrVec[4] |-> rxFrameInfoWord.payloadLen < 16'h0600)
      else $error("length error without a length field");
   AST_OVERSIZE: assert property (rxFrameInfoStrobe |->
                                  rxErrVec[3] == (rxFrameInfoWord.frameLen > $past(s_reg.maxSize)))
      else $error("oversize flag disagrees with programmed maximum");
   AST_UNDERSIZE: assert property (rxFrameInfoStrobe |-> rxErrVec[2] == (rxFrameInfoWord.frameLen < 16'h0040))
      else $error("undersize flag disagrees with frame length");
   AST_MALFORMED: assert property (inValid && inBeat.last && inBeat.badTerm |=> rxErrVec[0] && rxErrVec[1])
      else $error("malformed frame missing error bits");
   AST_STROBE_AT_END: assert property (rxFrameInfoStrobe == (rxValid && rxLastBeat))
      else $error("status strobe not aligned with end of packet");
   AST_ADDR_CLASS: assert property (rxFrameInfoStrobe |->
                                    (rxFrameInfoWord.unicast != (rxFrameInfoWord.multicast || rxFrameInfoWord.broadcast)))
      else $error("address class flags inconsistent");
   AST_PAUSE_IS_CTRL: assert property (rxFrameInfoStrobe && (rxFrameInfoWord.pause || rxFrameInfoWord.pfc) |-> rxFrameInfoWord.control)
      else $error("pause frame not marked as control");
   AST_PAYLOAD_FITS: assert property (rxFrameInfoStrobe |-> rxFrameInfoWord.payloadLen <= rxFrameInfoWord.frameLen)
      else $error("payload longer than frame");
   AST_PAUSE_HOLD: assert property ($rose(pauseVec[0]) |->
                                    rxFrameInfoStrobe && rxErrVec == 6'h00
                                    && (rxFrameInfoWord.pause || rxFrameInfoWord.pfc))
      else $error("pause indication raised without a clean pause frame");
   AST_EMPTY_AT_END: assert property (rxUnusedByteCount != 3'h0 |-> rxLastBeat)
      else $error("unused byte count outside end of packet");
   AST_FIRST_FOLLOWS: assert property (inValid && inBeat.first |=> rxFirstBeat && rxValid)
      else $error("start indication lost");
   AST_RESET_QUIET: assert property (@(posedge clock) disable iff (1'b0)
                                     !rst_b |-> !rxFrameInfoStrobe && rxErrVec == 6'h00 && pauseVec == '0)
      else $error("outputs active during reset");

   COV_CRC_ERR: cover property (rxFrameInfoStrobe && rxErrVec[1]);
   COV_MALFORMED: cover property (rxFrameInfoStrobe && rxErrVec[0]);
   COV_PAUSE: cover property ($rose(pauseVec[0]));
   COV_CLEAN: cover property (rxFrameInfoStrobe && rxErrVec == 6'h00);

endmodule
`default_nettype wire

// ==== verif/rfesr_client_model.sv ====
// client side model that consumes received frames and counts them
`timescale 1ns/10ps
`default_nettype none
module rfesr_client_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   // received stream
   input  wire logic       rxValid,
   input  wire logic       rxFirstBeat,
   // frames seen
   output logic [7:0]      frameCount
);
   // no back-pressure exists, so every beat is taken at once
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         frameCount <= 8'h00;
      end else if (rxValid && rxFirstBeat) begin
         frameCount <= frameCount + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the receive frame error and status reporter
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clock = 1'b0, rst_b = 1'b0, inValid = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
   logic rxValid, rxFirstBeat, rxLastBeat, rxFrameInfoStrobe;
   rfesr_pkg::rfesr_beat_t inBeat = '0;
   rfesr_pkg::rfesr_info_t rxFrameInfoWord;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, frameCount, pauseVec;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic [2:0]  rxUnusedByteCount;
   logic [5:0]  rxErrVec;
   logic [33:0] r;
   logic [48:0] exp_q[$];
   int n_mismatch = 0, samples_checked = 0;

   always #50 clock = ~clock;

   rfesr_rx_report uut (.clock(clock), .rst_b(rst_b), .inValid(inValid), .inBeat(inBeat), .rxValid(rxValid),
      .rxData(), .rxFirstBeat(rxFirstBeat), .rxLastBeat(rxLastBeat), .rxUnusedByteCount(rxUnusedByteCount),
      .rxErrVec(rxErrVec), .rxFrameInfoStrobe(rxFrameInfoStrobe), .rxFrameInfoWord(rxFrameInfoWord),
      .pauseVec(pauseVec), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   rfesr_client_model client (.clock(clock), .rst_b(rst_b), .rxValid(rxValid), .rxFirstBeat(rxFirstBeat),
      .frameCount(frameCount));

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_frame(input logic [48:0] e, input logic [48:0] g);
      samples_checked++;
      if (g !== e) begin n_mismatch++; $display("ERROR %0t exp %h got %h", $time, e, g); end
   endtask
   task automatic check_reg(input logic [33:0] g, input logic [33:0] e);
      samples_checked++;
      if (g !== e) begin n_mismatch++; $display("ERROR %0t exp %h got %h", $time, e, g); end
   endtask
   task automatic hung();
      n_mismatch++;
      test_done();
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clock); awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (t == 50) hung();
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [33:0] q);
      int t;
      @(posedge clock); araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      q = {rresp, rdata};
      rready <= 1'b0;
      if (t == 50) hung();
   endtask
   // mode 0 clean, 1 corrupt check sequence, 2 ended by a non-terminate control
   task automatic send(input int n, input logic [15:0] typ, input int mode, input logic [5:0] err);
      logic [7:0]  b[$];
      logic [31:0] c;
      logic [63:0] d;
      b = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, typ[15:8], typ[7:0]};
      // control type: pause opcode and 16 quanta
      if (typ == 16'h8808) b = {b, 8'h00, 8'h01, 8'h00, 8'h10};
      while (b.size() < n - 4) b.push_back(8'($urandom));
      c = 32'hffffffff;
      foreach (b[i]) begin
         c ^= {24'h0, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ rfesr_pkg::CRC_POLY : c >> 1;
      end
      c = ~c;
      for (int k = 0; k < 4; k++) b.push_back(c[8*k +: 8]);
      if (mode == 1) b[n-1] = ~b[n-1];
      exp_q.push_back({err, 3'(8*((n+7)/8) - n), (typ == 16'h8808) ? 8'h4c : 8'h40, 16'(n), 16'(n - 18)});
      for (int k = 0; k < n; k += 8) begin
         d = '0;
         for (int j = 0; j < 8; j++) if (k + j < n) d[63-8*j -: 8] = b[k+j];
         @(posedge clock);
         inValid <= 1'b1;
         inBeat <= '{data: d, first: k == 0, last: k + 8 >= n, empty: 3'(8*((n+7)/8) - n),
                     badTerm: mode == 2 && k + 8 >= n};
      end
      @(posedge clock); inValid <= 1'b0; inBeat <= '0;
   endtask

   always @(posedge clock) begin
      if (rst_b && rxFrameInfoStrobe === 1'b1) begin
         if (exp_q.size() == 0) check_reg(34'h1, 34'h0);
         else check_frame(exp_q.pop_front(), {rxErrVec, rxUnusedByteCount, rxFrameInfoWord});
      end
   end

   initial begin
      void'($urandom(32'h4bec1d53));
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      axi_rd(rfesr_pkg::ADDR_MAX_SIZE, r); check_reg(r, {rfesr_pkg::RESP_OKAY, 16'h0, rfesr_pkg::MAX_FRAME_RESET});
      send(64, 16'h0800, 0, 6'h00);
      send(64, 16'h0800, 1, 6'h02);
      send(69, 16'h0800, 2, 6'h03);
      send(60, 16'h0800, 0, 6'h04);
      send(64, 16'h0064, 0, 6'h10);
      axi_wr(rfesr_pkg::ADDR_MAX_SIZE, 32'h64);
      send(120, 16'h0800, 0, 6'h08);
      repeat (4) @(posedge clock);
      check_reg({33'h0, irq}, 34'h0);
      axi_rd(rfesr_pkg::ADDR_IRQ_STATUS, r); check_reg(r, {rfesr_pkg::RESP_OKAY, 32'h1f});
      axi_wr(rfesr_pkg::ADDR_IRQ_MASK, 32'h2); repeat (3) @(posedge clock);
      check_reg({33'h0, irq}, 34'h1);
      axi_wr(rfesr_pkg::ADDR_IRQ_STATUS, 32'h1f); repeat (3) @(posedge clock);
      check_reg({33'h0, irq}, 34'h0);
      send(64, 16'h8808, 0, 6'h00);
      @(posedge clock);
      check_reg({26'h0, pauseVec}, 34'hff);
      repeat (20) @(posedge clock);
      check_reg({26'h0, pauseVec}, 34'h0);
      axi_rd(8'h20, r); check_reg(r, {rfesr_pkg::RESP_SLVERR, 32'h0});
      check_reg({26'h0, frameCount}, 34'h7);
      check_reg(34'(exp_q.size()), 34'h0);
      test_done();
   end
endmodule
`default_nettype wire
